// [src/cdms_cfg.svh]
// Register map, field positions and reset values of the clock divider block.
// Assumes inclusion by the block top only; the block package does not include it.
`ifndef CDMS_CFG_SVH
`define CDMS_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CDMS_ADDR_W 8
`define CDMS_DIV_CTRL_OFF 8'h00
`define CDMS_STBY_OFF 8'h04
`define CDMS_STATUS_OFF 8'h08

// ----------------------------------------
// Divider control fields
// ----------------------------------------
`define CDMS_CORE_LSB 12
`define CDMS_BUS_LSB 9
`define CDMS_PERIPH_LSB 6
`define CDMS_FAST_TMR_LSB 3
`define CDMS_SLOW_TMR_LSB 0
`define CDMS_DIV_RSVD_BIT 15
`define CDMS_DIV_CTRL_RST 15'h0000

// ----------------------------------------
// Module standby fields
// ----------------------------------------
`define CDMS_STOP_LSB 2
`define CDMS_STBY_RSVD 2'h3
`define CDMS_STBY_RST 6'h3F

`endif

// [src/cdms_pkg.sv]
// Types shared by the clock divider and module stop block.
// Assumes nothing from the constants header; it includes no other file.
package cdms_pkg;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef logic [2:0] cdms_div_t;

    typedef struct packed {
        logic [14:0] div_ctrl;
        logic [5:0] stop;
        logic [4:0][2:0] cnt;
        logic [4:0] tick;
        logic [5:0] run;
        logic pd_meta;
        logic pd_sync;
        logic [15:0] rdata;
    } cdms_state_s;

endpackage

// [src/cdms_top.sv]
// Clock divider control and per-module clock stop for a small controller.
// Assumes one system clock; the derived clocks leave as one-cycle enable
// pulses, and POWER_DOWN arrives asynchronously from the power controller.
`timescale 1ns/1ps

`include "cdms_cfg.svh"

module cdms_top
    import cdms_pkg::*;
(
    input wire logic CLK_SYS, // System clock, 50 MHz
    input wire logic RST_B, // Synchronous reset, active low
    input wire logic [`CDMS_ADDR_W-1:0] ADDR, // Register byte address
    input wire logic [15:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    input wire logic POWER_DOWN, // Power-down request, asynchronous
    output logic [15:0] RDATA, // Read data, cycle after RD
    output logic CORE_TICK, // Core clock enable
    output logic BUS_TICK, // Bus clock enable
    output logic PERIPH_TICK, // Peripheral clock enable
    output logic FAST_TMR_TICK, // Fast timer clock enable
    output logic SLOW_TMR_TICK, // Slow timer clock enable
    output logic SYNC_SER_EN, // Sync serial unit clock enable
    output logic ASYNC_ZERO_EN, // Async serial channel 0 enable
    output logic ASYNC_ONE_EN, // Async serial channel 1 enable
    output logic ASYNC_TWO_EN, // Async serial channel 2 enable
    output logic FIFO_SER_EN, // FIFO serial unit enable
    output logic TWO_WIRE_TWO_EN // Second two-wire unit enable
);

    // ----------------------------------------
    // Constants
    // ----------------------------------------
    localparam int NUM_DIV = 5;
    localparam int NUM_MOD = 6;
    localparam int IDX_CORE = 0;
    localparam int IDX_BUS = 1;
    localparam int IDX_PERIPH = 2;
    localparam int IDX_FAST = 3;
    localparam int IDX_SLOW = 4;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    // Divider code of one derived clock; ratio is 1/(code+1)
    function automatic cdms_div_t div_code(
        input logic [14:0] ctrl,
        input int idx
    );
        cdms_div_t code;
        code = 3'h0;
        case (idx)
            IDX_CORE: begin
                code = ctrl[`CDMS_CORE_LSB +: 3];
            end
            IDX_BUS: begin
                code = ctrl[`CDMS_BUS_LSB +: 3];
            end
            IDX_PERIPH: begin
                code = ctrl[`CDMS_PERIPH_LSB +: 3];
            end
            IDX_FAST: begin
                code = ctrl[`CDMS_FAST_TMR_LSB +: 3];
            end
            IDX_SLOW: begin
                code = ctrl[`CDMS_SLOW_TMR_LSB +: 3];
            end
            default: begin
                code = 3'h0;
            end
        endcase
        return code;
    endfunction

    // Register select
    function automatic logic hit(
        input logic [`CDMS_ADDR_W-1:0] addr,
        input logic [`CDMS_ADDR_W-1:0] off
    );
        return addr == off;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    cdms_state_s cur;
    cdms_state_s next_cur;
    logic [15:0] div_view;
    logic [7:0] stby_view;
    logic [15:0] status_view;

    // ----------------------------------------
    // Register views
    // ----------------------------------------
    always_comb begin
        div_view = 16'h0000;
        div_view[14:0] = cur.div_ctrl;
        div_view[`CDMS_DIV_RSVD_BIT] = 1'b0;
    end

    always_comb begin
        stby_view = {cur.stop, `CDMS_STBY_RSVD};
    end

    always_comb begin
        status_view = 16'h0000;
        status_view[5:0] = cur.run;
        status_view[10:6] = cur.tick;
        status_view[11] = cur.pd_sync;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        cdms_div_t code;
        logic periph_next;
        code = 3'h0;
        periph_next = 1'b0;
        next_cur = cur;

        // Power-down request crosses into this domain
        next_cur.pd_meta = POWER_DOWN;
        next_cur.pd_sync = cur.pd_meta;

        // Register writes
        if (WR) begin
            if (hit(ADDR, `CDMS_DIV_CTRL_OFF)) begin
                // Reserved top bit is dropped, never stored
                next_cur.div_ctrl = WDATA[14:0];
            end
            if (hit(ADDR, `CDMS_STBY_OFF)) begin
                next_cur.stop = WDATA[7:`CDMS_STOP_LSB];
            end
        end

        // Register reads; unmapped addresses answer zero
        next_cur.rdata = 16'h0000;
        if (RD) begin
            if (hit(ADDR, `CDMS_DIV_CTRL_OFF)) begin
                next_cur.rdata = div_view;
            end else if (hit(ADDR, `CDMS_STBY_OFF)) begin
                next_cur.rdata = {8'h00, stby_view};
            end else if (hit(ADDR, `CDMS_STATUS_OFF)) begin
                next_cur.rdata = status_view;
            end else begin
                next_cur.rdata = 16'h0000;
            end
        end

        // Dividers; wrap on >= so a ratio cut mid-count never stalls
        for (int i = 0; i < NUM_DIV; i++) begin
            code = div_code(cur.div_ctrl, i);
            if (cur.cnt[i] >= code) begin
                next_cur.cnt[i] = 3'h0;
                next_cur.tick[i] = 1'b1;
            end else begin
                next_cur.cnt[i] = cur.cnt[i] + 3'h1;
                next_cur.tick[i] = 1'b0;
            end
        end

        // Core and bus halt in power-down; peripheral clock keeps running
        if (cur.pd_sync) begin
            next_cur.tick[IDX_CORE] = 1'b0;
            next_cur.tick[IDX_BUS] = 1'b0;
        end

        // Module enables follow the peripheral clock unless stopped.
        // Gating an enable leaves module state intact: no reset is sent.
        periph_next = next_cur.tick[IDX_PERIPH];
        for (int m = 0; m < NUM_MOD; m++) begin
            next_cur.run[m] = periph_next & ~next_cur.stop[m];
        end

        // Reset
        if (!RST_B) begin
            next_cur.div_ctrl = `CDMS_DIV_CTRL_RST;
            next_cur.stop = `CDMS_STBY_RST;
            next_cur.cnt = '0;
            next_cur.tick = '0;
            next_cur.run = '0;
            next_cur.pd_meta = 1'b0;
            next_cur.pd_sync = 1'b0;
            next_cur.rdata = 16'h0000;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge CLK_SYS) begin
        cur <= next_cur;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // All straight from state flip-flops
    assign RDATA = cur.rdata;
    assign CORE_TICK = cur.tick[IDX_CORE];
    assign BUS_TICK = cur.tick[IDX_BUS];
    assign PERIPH_TICK = cur.tick[IDX_PERIPH];
    assign FAST_TMR_TICK = cur.tick[IDX_FAST];
    assign SLOW_TMR_TICK = cur.tick[IDX_SLOW];
    // Stop bit 2 is the sync serial unit; clear means it keeps running
    assign SYNC_SER_EN = cur.run[0];
    assign ASYNC_ZERO_EN = cur.run[1];
    assign ASYNC_ONE_EN = cur.run[2];
    assign ASYNC_TWO_EN = cur.run[3];
    assign FIFO_SER_EN = cur.run[4];
    assign TWO_WIRE_TWO_EN = cur.run[5];

endmodule

// [tb/cdms_properties.sv]
// Checker for the clock divider block: readback, tick ratios, module stops.
// Assumes it sees only the top ports; helper logic mirrors register writes.
`timescale 1ns/1ps
module cdms_properties (
    input wire logic CLK_SYS, // Clock
    input wire logic RST_B, // Reset
    input wire logic [7:0] ADDR, // Address
    input wire logic [15:0] WDATA, // Write data
    input wire logic WR, // Write
    input wire logic RD, // Read
    input wire logic POWER_DOWN, // Power-down
    input wire logic [15:0] RDATA, // Read data
    input wire logic CORE_TICK, // Core
    input wire logic BUS_TICK, // Bus
    input wire logic PERIPH_TICK, // Peripheral
    input wire logic FAST_TMR_TICK, // Fast timer
    input wire logic SLOW_TMR_TICK, // Slow timer
    input wire logic SYNC_SER_EN, // Sync serial
    input wire logic ASYNC_ZERO_EN, // Async 0
    input wire logic ASYNC_ONE_EN, // Async 1
    input wire logic ASYNC_TWO_EN, // Async 2
    input wire logic FIFO_SER_EN, // FIFO serial
    input wire logic TWO_WIRE_TWO_EN // Two-wire 2
);
    logic [15:0] div;
    logic [5:0] stb;
    logic [2:0] quiet;
    // ----------------------------------------
    // Mirrors; quiet waits out ratio changes and power-down
    // ----------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            div <= 16'h0000;
            stb <= 6'h3F;
            quiet <= 3'h0;
        end else begin
            if (WR && ADDR == 8'h00) div <= WDATA;
            if (WR && ADDR == 8'h04) stb <= WDATA[7:2];
            quiet <= (WR && ADDR == 8'h00 || POWER_DOWN) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    a_div_readback: assert property ($past(RD && ADDR == 8'h00)
        |-> RDATA == {1'b0, div[14:0]}) else $error("divider readback");
    a_stby_readback: assert property ($past(RD && ADDR == 8'h04)
        |-> RDATA == {8'h00, stb, 2'h3}) else $error("standby readback");
    a_core_ratio: assert property (quiet == 3'h7 && div[14:12] == 3'h0
        |-> CORE_TICK) else $error("core ratio");
    a_bus_ratio: assert property (quiet == 3'h7 && div[11:9] == 3'h1
        |-> BUS_TICK != $past(BUS_TICK)) else $error("bus ratio");
    a_periph_ratio: assert property (quiet == 3'h7 && div[8:6] == 3'h1
        |-> PERIPH_TICK != $past(PERIPH_TICK)) else $error("periph ratio");
    a_fast_ratio: assert property (quiet == 3'h7 && div[5:3] == 3'h0
        |-> FAST_TMR_TICK) else $error("fast timer ratio");
    a_pd_halt: assert property (POWER_DOWN [*5]
        |-> !CORE_TICK && !BUS_TICK) else $error("power-down ticks");
    a_sync_run: assert property (!stb[0] && !$past(stb[0])
        |-> SYNC_SER_EN == PERIPH_TICK) else $error("sync serial run");
    a_slow_ratio: assert property (quiet == 3'h7 && div[2:0] == 3'h1
        |-> SLOW_TMR_TICK != $past(SLOW_TMR_TICK)) else $error("slow timer ratio");
    a_serial_stop: assert property (((stb[5:1] & $past(stb[5:1])) & {TWO_WIRE_TWO_EN,
        FIFO_SER_EN, ASYNC_TWO_EN, ASYNC_ONE_EN, ASYNC_ZERO_EN}) == 5'h00)
        else $error("serial stop");
    a_sync_stop: assert property (stb[0] && $past(stb[0])
        |-> !SYNC_SER_EN) else $error("sync serial stop");
endmodule
bind cdms_top cdms_properties u_cdms_properties (.*);

// [tb/cdms_top_tb_top.sv]
// Testbench for the clock divider block: register access, ratios, stops.
// Assumes the design top and the checker bind are compiled before it.
`timescale 1ns/1ps
module cdms_top_tb_top;
    logic CLK_SYS = 1'b0, RST_B = 1'b0, WR = 1'b0, RD = 1'b0, POWER_DOWN = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [15:0] WDATA = 16'h0000;
    logic [15:0] RDATA;
    logic CORE_TICK, BUS_TICK, PERIPH_TICK, FAST_TMR_TICK, SLOW_TMR_TICK, SYNC_SER_EN;
    logic ASYNC_ZERO_EN, ASYNC_ONE_EN, ASYNC_TWO_EN, FIFO_SER_EN, TWO_WIRE_TWO_EN;
    int fails = 0, n_checks = 0;
    int n[7];
    cdms_top u_cdms_top (.*);
    always #10 CLK_SYS = ~CLK_SYS;
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge CLK_SYS) {WR, ADDR, WDATA} <= {1'b1, a, d};
        @(posedge CLK_SYS) WR <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [15:0] exp);
        @(posedge CLK_SYS) {RD, ADDR} <= {1'b1, a};
        @(posedge CLK_SYS) RD <= 1'b0;
        @(negedge CLK_SYS) chk("rdata", RDATA, exp);
    endtask
    // Counts enables over 20 cycles once the new setting has settled
    task automatic cnt();
        n = '{default: 0};
        repeat (5) @(posedge CLK_SYS);
        repeat (20) begin
            @(negedge CLK_SYS);
            n[0] += CORE_TICK;
            n[1] += BUS_TICK;
            n[2] += PERIPH_TICK;
            n[3] += FAST_TMR_TICK;
            n[4] += SLOW_TMR_TICK;
            n[5] += SYNC_SER_EN;
            n[6] += ASYNC_ZERO_EN + ASYNC_ONE_EN + ASYNC_TWO_EN + FIFO_SER_EN + TWO_WIRE_TWO_EN;
        end
    endtask
    task automatic test_done();
        if (fails == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge CLK_SYS);
        RST_B <= 1'b1;
        rd(8'h00, 16'h0000);
        rd(8'h04, 16'h00FF);
        rd(8'h08, 16'h07C0);
        wr(8'h0C, 16'hFFFF);
        rd(8'h0C, 16'h0000);
        wr(8'h00, 16'h8241);
        rd(8'h00, 16'h0241);
        wr(8'h04, 16'h0003);
        rd(8'h04, 16'h0003);
        cnt();
        chk("core", 16'(n[0]), 16'h0014);
        chk("bus", 16'(n[1]), 16'h000A);
        chk("periph", 16'(n[2]), 16'h000A);
        chk("fast", 16'(n[3]), 16'h0014);
        chk("slow", 16'(n[4]), 16'h000A);
        chk("serial", 16'(n[6]), 16'h0032);
        wr(8'h04, 16'h00FB);
        cnt();
        chk("sync", 16'(n[5]), 16'h000A);
        chk("stopped", 16'(n[6]), 16'h0000);
        @(posedge CLK_SYS) POWER_DOWN <= 1'b1;
        cnt();
        chk("pd core", 16'(n[0] + n[1]), 16'h0000);
        chk("pd sync", 16'(n[5] + n[2]), 16'h0014);
        wr(8'h00, 16'h0000);
        rd(8'h08, 16'h0F01);
        test_done();
    end
endmodule
